// *** hdl/sanitize_pkg.sv ***
package sanitize_pkg;
    // ******************************************
    // command decoding
    // ******************************************
    localparam logic [15:0] FEAT_STATUS = 16'h0000;
    localparam logic [15:0] FEAT_CRYPTO = 16'h0011;
    localparam logic [15:0] FEAT_OVERWRITE = 16'h0014;
    localparam logic [15:0] FEAT_FREEZE = 16'h0020;
    localparam logic [31:0] CRYPTO_KEY = 32'h4372_7970;
    localparam logic [15:0] OVERWRITE_KEY = 16'h4f57;
    localparam logic [31:0] FREEZE_KEY = 32'h4672_4c6b;
    // ******************************************
    // count, status and error field positions
    // ******************************************
    localparam int CNT_ZONED_BIT = 15;
    localparam int CNT_INVERT_BIT = 7;
    localparam int CNT_DEFEND_BIT = 6;
    localparam int CNT_FMODE_BIT = 4;
    localparam int CNT_CLEAR_BIT = 0;
    localparam int OUT_OK_BIT = 15;
    localparam int OUT_BUSY_BIT = 14;
    localparam int OUT_FROZEN_BIT = 13;
    localparam int OUT_ANTIFREEZE_BIT = 12;
    localparam int STATUS_ERR_BIT = 0;
    localparam int ERROR_ABORT_BIT = 2;
    // ******************************************
    // reason codes and progress
    // ******************************************
    localparam logic [7:0] REASON_NONE = 8'h00;
    localparam logic [7:0] REASON_UNSANITIZED = 8'h01;
    localparam logic [7:0] REASON_BAD_FEATURE = 8'h02;
    localparam logic [7:0] REASON_FROZEN = 8'h03;
    localparam logic [7:0] REASON_ANTIFREEZE = 8'h04;
    localparam logic [15:0] PROGRESS_NONE = 16'hffff;
    localparam logic [15:0] PROGRESS_ZERO = 16'h0000;
    localparam logic [4:0] PASSES_FOR_ZERO = 5'h10;
    localparam logic [4:0] PROGRESS_STEPS = 5'h10;
    localparam int UNIT_W = 36;

    // gray order along idle -> running -> succeeded -> failed -> frozen
    typedef enum logic [2:0] {
        SD0_IDLE = 3'h0,
        SD2_RUNNING = 3'h1,
        SD4_SUCCEEDED = 3'h3,
        SD3_FAILED = 3'h2,
        SD1_FROZEN = 3'h6
    } san_state_e;
endpackage

// *** hdl/sanitize_if.sv ***
`timescale 1ns/100ps
interface sanitize_if;
    logic start;
    logic [31:0] pattern;
    logic invert;
    logic def_end;
    logic [3:0] pass_cnt;
    logic [31:0] scope_words;
    logic busy;
    logic [sanitize_pkg::UNIT_W-1:0] units_done;
    logic [sanitize_pkg::UNIT_W-1:0] units_total;
    logic [15:0] frac;
    modport ctrl (output start, pattern, invert, def_end, pass_cnt,
        scope_words, input busy, frac);
    modport seq (input start, pattern, invert, def_end, pass_cnt,
        scope_words, output busy, units_done, units_total);
    modport prog (input units_done, units_total, output frac);
endinterface

// *** hdl/overwrite_sequencer.sv ***
`timescale 1ns/100ps
module overwrite_sequencer (
    input wire logic core_clk_i,
    input wire logic reset_i,
    sanitize_if.seq ctl,
    input wire logic wr_ready_i,
    output logic wr_valid_o,
    output logic [31:0] wr_data_o
);
    logic busy_reg;
    logic inv_reg;
    logic [31:0] word_reg;
    logic [4:0] pass_reg;
    logic [4:0] passes_reg;
    logic [sanitize_pkg::UNIT_W-1:0] done_reg;
    wire [4:0] passes_next = (ctl.pass_cnt == 4'h0) ?
        sanitize_pkg::PASSES_FOR_ZERO : {1'b0, ctl.pass_cnt};
    // even count starts inverted so the last pass is the plain pattern
    wire inv_first = ctl.invert & ctl.def_end & ~ctl.pass_cnt[0];
    wire word_last = (word_reg == ctl.scope_words - 32'h1);
    wire pass_last = (pass_reg == passes_reg - 5'h1);
    wire step = busy_reg & wr_ready_i;

    assign ctl.busy = busy_reg;
    assign ctl.units_done = done_reg;
    assign ctl.units_total = sanitize_pkg::UNIT_W'(passes_reg) *
        sanitize_pkg::UNIT_W'(ctl.scope_words);
    assign wr_valid_o = busy_reg;

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            busy_reg <= 1'b0;
            inv_reg <= 1'b0;
            word_reg <= 32'h0;
            pass_reg <= 5'h0;
            passes_reg <= 5'h1;
            done_reg <= '0;
            wr_data_o <= 32'h0;
        end else if (ctl.start) begin
            // without a requested ending pattern, plain comes first
            busy_reg <= 1'b1;
            // held here: the command fields move on with the next command
            inv_reg <= ctl.invert;
            word_reg <= 32'h0;
            pass_reg <= 5'h0;
            passes_reg <= passes_next;
            done_reg <= '0;
            wr_data_o <= ctl.pattern ^ {32{inv_first}};
        end else if (step) begin
            done_reg <= done_reg + 1'b1;
            // the 32-bit pattern repeats across the whole scope
            word_reg <= word_last ? 32'h0 : word_reg + 32'h1;
            if (word_last) begin
                pass_reg <= pass_reg + 5'h1;
                busy_reg <= ~pass_last;
                wr_data_o <= wr_data_o ^ {32{inv_reg}};
            end
        end
    end

    pass_flip_a: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        step && word_last && !pass_last |=>
        wr_data_o == ($past(wr_data_o) ^ {32{inv_reg}}))
        else $error("pattern not flipped correctly between passes");
    zero_count_a: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        ctl.start && ctl.pass_cnt == 4'h0 |=> passes_reg == 5'h10)
        else $error("pass count zero did not give sixteen passes");
endmodule // overwrite_sequencer

// *** hdl/sanitize_progress.sv ***
`timescale 1ns/100ps
module sanitize_progress (
    input wire logic core_clk_i,
    input wire logic reset_i,
    sanitize_if.prog prg
);
    // serial restoring divide: one quotient bit per cycle keeps area small;
    // the fraction refreshes every seventeen cycles
    logic [sanitize_pkg::UNIT_W:0] rem_reg;
    logic [15:0] quo_reg;
    logic [4:0] step_reg;
    logic [15:0] frac_reg;
    wire [sanitize_pkg::UNIT_W:0] rem_sh = {rem_reg[sanitize_pkg::UNIT_W-1:0],
        1'b0};
    wire [sanitize_pkg::UNIT_W:0] total = {1'b0, prg.units_total};
    wire fits = rem_sh >= total;

    assign prg.frac = frac_reg;

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            rem_reg <= '0;
            quo_reg <= 16'h0;
            step_reg <= 5'h0;
            frac_reg <= 16'h0;
        end else if (step_reg == sanitize_pkg::PROGRESS_STEPS) begin
            // the sixteenth quotient bit is taken on the publishing cycle
            frac_reg <= {quo_reg[14:0], fits};
            step_reg <= 5'h0;
        end else begin
            if (step_reg == 5'h0) begin
                rem_reg <= {1'b0, prg.units_done};
                quo_reg <= 16'h0;
            end else begin
                rem_reg <= fits ? rem_sh - total : rem_sh;
                quo_reg <= {quo_reg[14:0], fits};
            end
            step_reg <= step_reg + 5'h1;
        end
    end
endmodule // sanitize_progress

// *** hdl/sanitize_command_handler.sv ***
`timescale 1ns/100ps
// Functional notes
// - Failed command returns reason 00h, 02h or 03h in LBA low byte.
// - Reason 01h when finished operation left some user sectors unsanitized.
// - Reason 04h when freeze lock fails due to antifreeze set.
// - Crypto scramble only if supported and state is idle, failed or succeeded.
// - With failure mode set, a good status command may leave failed state.
// - Failed state without failure mode aborts new failure-mode requests.
// - Completed-without-error flag puts machine in succeeded; survives power-on.
// - Progress is numerator over 65536 while running, all ones otherwise.
// - Successful freeze lock since power-on aborts crypto and overwrite.
// - Count field: zoned 15, invert 7, ending 6, failure mode 4, passes 3:0.
// - Invert bit flips the pattern every pass; otherwise pattern stays.
// - Invert plus ending pattern: first pass inverted if count even.
// - Invert without ending pattern: first pass may be either pattern.
// - Perform the pass count of passes; zero means sixteen.
// - Repeat the 32-bit pattern to fill every sector in scope.
// - After a good overwrite, blocks read back without error.
// - Normal output count bit 14 running, bit 13 frozen.
module sanitize_command_handler (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic cmd_valid_i,
    input wire logic [15:0] cmd_feature_i,
    input wire logic [15:0] cmd_count_i,
    input wire logic [47:0] cmd_lba_i,
    input wire logic sanitize_supported_i,
    input wire logic encryption_model_i,
    input wire logic def_end_supported_i,
    input wire logic antifreeze_i,
    input wire logic [31:0] scope_words_i,
    input wire logic nv_ok_i,
    output logic nv_ok_o,
    output logic key_change_req_o,
    input wire logic key_change_done_i,
    input wire logic media_fault_i,
    output logic wr_valid_o,
    input wire logic wr_ready_i,
    output logic [31:0] wr_data_o,
    output logic media_read_ok_o,
    output logic [2:0] state_o,
    output logic rsp_valid_o,
    output logic [7:0] rsp_status_o,
    output logic [7:0] rsp_error_o,
    output logic [15:0] rsp_count_o,
    output logic [47:0] rsp_lba_o
);
    // ******************************************
    // state
    // ******************************************
    sanitize_pkg::san_state_e state_reg;
    sanitize_pkg::san_state_e state_next;
    logic ok_reg;
    logic last_fm_reg;
    logic unsan_reg;
    logic fault_reg;
    logic is_ow_reg;
    logic key_wait_reg;
    logic seq_busy_reg;
    logic boot_reg;
    logic key_req_reg;

    sanitize_if sif ();

    overwrite_sequencer u_seq (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .ctl(sif.seq),
        .wr_ready_i(wr_ready_i),
        .wr_valid_o(wr_valid_o),
        .wr_data_o(wr_data_o)
    );

    sanitize_progress u_prog (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .prg(sif.prog)
    );

    // ******************************************
    // command decode
    // ******************************************
    wire is_status = cmd_feature_i == sanitize_pkg::FEAT_STATUS;
    wire is_crypto = cmd_feature_i == sanitize_pkg::FEAT_CRYPTO;
    wire is_ow = cmd_feature_i == sanitize_pkg::FEAT_OVERWRITE;
    wire is_freeze = cmd_feature_i == sanitize_pkg::FEAT_FREEZE;
    wire feat_ok = is_status | is_freeze | is_ow |
        (is_crypto & encryption_model_i);
    wire key_ok = is_ow ?
        cmd_lba_i[47:32] == sanitize_pkg::OVERWRITE_KEY :
        cmd_lba_i[31:0] == sanitize_pkg::CRYPTO_KEY;
    wire fm_req = cmd_count_i[sanitize_pkg::CNT_FMODE_BIT];
    wire st_idle = state_reg == sanitize_pkg::SD0_IDLE;
    wire st_run = state_reg == sanitize_pkg::SD2_RUNNING;
    wire st_fail = state_reg == sanitize_pkg::SD3_FAILED;
    wire st_good = state_reg == sanitize_pkg::SD4_SUCCEEDED;
    wire st_frozen = state_reg == sanitize_pkg::SD1_FROZEN;
    wire start_ok = st_idle | st_fail | st_good;
    wire fm_block = st_fail & ~last_fm_reg & fm_req;
    wire freeze_key_ok = cmd_lba_i[31:0] == sanitize_pkg::FREEZE_KEY;

    // ******************************************
    // abort decision and reason
    // ******************************************
    wire op_abort = st_frozen | ~start_ok | fm_block | ~key_ok;
    wire freeze_abort = antifreeze_i | st_frozen | st_run | ~freeze_key_ok;
    wire status_abort = st_fail & unsan_reg;
    wire abort = ~sanitize_supported_i | ~feat_ok |
        (is_status ? status_abort : is_freeze ? freeze_abort : op_abort);
    wire [7:0] reason =
        !sanitize_supported_i ? sanitize_pkg::REASON_NONE :
        !feat_ok ? sanitize_pkg::REASON_BAD_FEATURE :
        is_status ? sanitize_pkg::REASON_UNSANITIZED :
        is_freeze && antifreeze_i ? sanitize_pkg::REASON_ANTIFREEZE :
        st_frozen ? sanitize_pkg::REASON_FROZEN :
        sanitize_pkg::REASON_NONE;
    wire take = cmd_valid_i & ~boot_reg;
    wire start_op = take & ~abort & (is_ow | is_crypto);
    wire status_ok = take & ~abort & is_status;
    wire exit_fail = status_ok & st_fail & last_fm_reg;
    wire seq_end = seq_busy_reg & ~sif.busy;
    wire op_end = seq_end | (key_wait_reg & key_change_done_i);
    wire [15:0] progress = !st_run ? sanitize_pkg::PROGRESS_NONE :
        is_ow_reg ? sif.frac : sanitize_pkg::PROGRESS_ZERO;
    wire [15:0] count_normal = 16'h0 |
        (16'(ok_reg) << sanitize_pkg::OUT_OK_BIT) |
        (16'(st_run) << sanitize_pkg::OUT_BUSY_BIT) |
        (16'(st_frozen) << sanitize_pkg::OUT_FROZEN_BIT) |
        (16'(antifreeze_i) << sanitize_pkg::OUT_ANTIFREEZE_BIT);

    assign sif.start = start_op & is_ow;
    assign sif.pattern = cmd_lba_i[31:0];
    assign sif.invert = cmd_count_i[sanitize_pkg::CNT_INVERT_BIT];
    assign sif.def_end = cmd_count_i[sanitize_pkg::CNT_DEFEND_BIT] &
        def_end_supported_i;
    assign sif.pass_cnt = cmd_count_i[3:0];
    assign sif.scope_words = scope_words_i;
    assign nv_ok_o = ok_reg;
    assign key_change_req_o = key_req_reg;
    // reads are held off only while a sanitize operation (overwrite or crypto scramble) is running
    assign media_read_ok_o = ~st_run;
    assign state_o = state_reg;

    // ******************************************
    // sanitize state machine
    // ******************************************
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            sanitize_pkg::SD0_IDLE,
            sanitize_pkg::SD4_SUCCEEDED: begin
                if (start_op) begin
                    state_next = sanitize_pkg::SD2_RUNNING;
                end else if (take && is_freeze && !abort) begin
                    state_next = sanitize_pkg::SD1_FROZEN;
                end
            end
            sanitize_pkg::SD3_FAILED: begin
                if (start_op) begin
                    state_next = sanitize_pkg::SD2_RUNNING;
                end else if (exit_fail) begin
                    state_next = sanitize_pkg::SD0_IDLE;
                end else if (take && is_freeze && !abort) begin
                    state_next = sanitize_pkg::SD1_FROZEN;
                end
            end
            sanitize_pkg::SD2_RUNNING: begin
                if (op_end) begin
                    state_next = (fault_reg | media_fault_i) ?
                        sanitize_pkg::SD3_FAILED :
                        sanitize_pkg::SD4_SUCCEEDED;
                end
            end
            // frozen is only left through reset
            sanitize_pkg::SD1_FROZEN: state_next = sanitize_pkg::SD1_FROZEN;
            default: state_next = sanitize_pkg::SD0_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state_reg <= sanitize_pkg::SD0_IDLE;
            boot_reg <= 1'b1;
        end else if (boot_reg) begin
            // the stored flag is caught after release, not under reset
            state_reg <= nv_ok_i ? sanitize_pkg::SD4_SUCCEEDED :
                sanitize_pkg::SD0_IDLE;
            boot_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ******************************************
    // operation bookkeeping
    // ******************************************
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            ok_reg <= 1'b0;
            last_fm_reg <= 1'b0;
            unsan_reg <= 1'b0;
            fault_reg <= 1'b0;
            is_ow_reg <= 1'b0;
            key_wait_reg <= 1'b0;
            key_req_reg <= 1'b0;
            seq_busy_reg <= 1'b0;
        end else begin
            seq_busy_reg <= sif.busy;
            key_req_reg <= start_op & is_crypto;
            if (boot_reg) begin
                ok_reg <= nv_ok_i;
            end else if (start_op) begin
                ok_reg <= 1'b0;
            end else if (st_run && op_end) begin
                ok_reg <= ~(fault_reg | media_fault_i);
            end
            if (start_op) begin
                last_fm_reg <= fm_req;
                is_ow_reg <= is_ow;
                fault_reg <= 1'b0;
                key_wait_reg <= is_crypto;
            end else if (st_run) begin
                fault_reg <= fault_reg | media_fault_i;
                if (op_end) begin
                    key_wait_reg <= 1'b0;
                end
            end
            // the unsanitized report is given once, then the failed
            // state may be left by a following status command
            if (st_run && op_end) begin
                unsan_reg <= fault_reg | media_fault_i;
            end else if (take && is_status && status_abort) begin
                unsan_reg <= 1'b0;
            end
        end
    end

    // ******************************************
    // command response
    // ******************************************
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            rsp_valid_o <= 1'b0;
            rsp_status_o <= 8'h00;
            rsp_error_o <= 8'h00;
            rsp_count_o <= 16'h0000;
            rsp_lba_o <= 48'h0;
        end else begin
            rsp_valid_o <= take;
            if (take) begin
                rsp_status_o <=
                    8'(abort) << sanitize_pkg::STATUS_ERR_BIT;
                rsp_error_o <= 8'(abort) << sanitize_pkg::ERROR_ABORT_BIT;
                rsp_count_o <= abort ? 16'h0000 : count_normal;
                rsp_lba_o <= abort ? {40'h0, reason} :
                    {32'h0, progress};
            end
        end
    end

    // ******************************************
    // checks
    // ******************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    sequence frozen_then_op;
        st_frozen ##0 take && (is_ow || is_crypto);
    endsequence
    sequence run_done_bad;
        st_run && op_end && (fault_reg || media_fault_i);
    endsequence
    sequence bad_key_op;
        take && sanitize_supported_i && (is_ow || is_crypto) && !key_ok;
    endsequence

    err_with_abort_a: assert property (rsp_valid_o |->
        rsp_status_o[0] == rsp_error_o[2])
        else $error("status error bit disagrees with abort");

    frozen_abort_a: assert property (frozen_then_op |=>
        rsp_valid_o && rsp_error_o[2] && rsp_lba_o[7:0] == 8'h03)
        else $error("frozen device accepted a sanitize operation");

    bad_feature_a: assert property (
        take && sanitize_supported_i && !feat_ok
        |=> rsp_lba_o[7:0] == 8'h02 && rsp_status_o[0])
        else $error("unsupported feature not reported");

    antifreeze_a: assert property (
        take && sanitize_supported_i && is_freeze && antifreeze_i
        |=> rsp_lba_o[7:0] == 8'h04)
        else $error("antifreeze freeze failure not reported");

    fail_state_a: assert property (run_done_bad |=>
        st_fail ##0 unsan_reg)
        else $error("faulty operation did not end in failed state");

    progress_idle_a: assert property (
        rsp_valid_o && !rsp_error_o[2] && !rsp_count_o[14]
        |-> rsp_lba_o[15:0] == 16'hffff)
        else $error("progress not all ones outside running state");

    crypto_state_a: assert property (take && is_crypto && !start_ok
        |=> rsp_error_o[2] && !key_change_req_o)
        else $error("crypto scramble accepted in wrong state");

    fm_block_a: assert property (take && feat_ok && fm_block
        |=> rsp_error_o[2] && st_fail)
        else $error("failure mode request not refused");

    ok_success_a: assert property (st_run && op_end && !fault_reg &&
        !media_fault_i |=> ok_reg && st_good)
        else $error("success did not set completed flag");

    key_req_a: assert property (start_op && is_crypto |=>
        key_change_req_o)
        else $error("key change not requested after crypto start");

    leave_fail_a: assert property (exit_fail |=>
        st_idle)
        else $error("failed state not left after status command");

    busy_bit_a: assert property (take && st_run && !abort |=>
        rsp_count_o[14])
        else $error("running bit missing from response");

    frozen_bit_a: assert property (take && st_frozen && !abort |=>
        rsp_count_o[13])
        else $error("frozen bit missing from response");

    read_ok_a: assert property (st_good |->
        media_read_ok_o)
        else $error("reads blocked after successful sanitize");

    boot_flag_a: assert property (boot_reg && nv_ok_i |=>
        st_good && nv_ok_o)
        else $error("stored completed flag not restored");

    bad_key_a: assert property (bad_key_op |=> rsp_error_o[2])
        else $error("sanitize operation with bad key accepted");
endmodule // sanitize_command_handler

// *** sim/media_model.sv ***
`timescale 1ns/100ps
module media_model (
    input wire logic core_clk_i,
    input wire logic wr_valid_i,
    input wire logic [31:0] wr_data_i,
    output logic wr_ready_o,
    input wire logic key_req_i,
    output logic key_done_o
);
    logic [31:0] words[$];
    logic [1:0] stall_reg = 2'h0;
    logic [2:0] key_reg = 3'h0;
    // ****************
    // media sink
    // ****************
    // one stall in three cycles, so a held word must survive the wait
    assign wr_ready_o = (stall_reg != 2'h2);
    assign key_done_o = (key_reg == 3'h1);
    always @(posedge core_clk_i) begin
        stall_reg <= (stall_reg == 2'h2) ? 2'h0 : stall_reg + 2'h1;
        if (wr_valid_i && wr_ready_o) begin
            words.push_back(wr_data_i);
        end
        if (key_req_i) begin
            key_reg <= 3'h4;
        end else if (key_reg != 3'h0) begin
            key_reg <= key_reg - 3'h1;
        end
    end
endmodule // media_model

// *** sim/sanitize_command_handler_tb.sv ***
`timescale 1ns/100ps
`define CK(nm, e, g) begin cmp_count++; if ((e) !== (g)) begin \
    fail_count++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module sanitize_command_handler_tb;
    typedef struct packed {
        logic [15:0] f;
        logic [47:0] l;
        logic e;
        logic [7:0] r;
    } row_s;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic cmd_valid_i = 1'b0;
    logic [15:0] cmd_feature_i = 16'h0000;
    logic [15:0] cmd_count_i = 16'h0000;
    logic [47:0] cmd_lba_i = 48'h0;
    logic sanitize_supported_i = 1'b1;
    logic encryption_model_i = 1'b1;
    logic def_end_supported_i = 1'b1;
    logic antifreeze_i = 1'b0;
    logic [31:0] scope_words_i = 32'h2;
    logic nv_ok_i = 1'b0;
    logic media_fault_i = 1'b0;
    logic nv_ok_o, key_change_req_o, key_change_done_i, wr_valid_o;
    logic wr_ready_i, media_read_ok_o, rsp_valid_o;
    logic [31:0] wr_data_o;
    logic [2:0] state_o;
    logic [7:0] rsp_status_o, rsp_error_o;
    logic [15:0] rsp_count_o;
    logic [47:0] rsp_lba_o;
    int fail_count = 0;
    int cmp_count = 0;
    row_s rows[5] = '{'{16'h0033, 48'h0, 1'b1, 8'h02},
        '{16'h0011, 48'h0, 1'b1, 8'h00}, '{16'h0014, 48'h4f56_0, 1'b1, 8'h00},
        '{16'h0020, 48'h0, 1'b1, 8'h00}, '{16'h0000, 48'h0, 1'b0, 8'hff}};
    sanitize_command_handler i_sanitize_command_handler (.core_clk_i,
        .reset_i, .cmd_valid_i, .cmd_feature_i, .cmd_count_i, .cmd_lba_i,
        .sanitize_supported_i, .encryption_model_i, .def_end_supported_i,
        .antifreeze_i, .scope_words_i, .nv_ok_i, .nv_ok_o, .key_change_req_o,
        .key_change_done_i, .media_fault_i, .wr_valid_o, .wr_ready_i,
        .wr_data_o, .media_read_ok_o, .state_o, .rsp_valid_o, .rsp_status_o,
        .rsp_error_o, .rsp_count_o, .rsp_lba_o);
    media_model i_media_model (.core_clk_i, .wr_valid_i(wr_valid_o),
        .wr_data_i(wr_data_o), .wr_ready_o(wr_ready_i),
        .key_req_i(key_change_req_o), .key_done_o(key_change_done_i));
    initial begin
        forever #4 core_clk_i = ~core_clk_i;
    end
    // ****************
    // helpers
    // ****************
    task cmd(input logic [15:0] f, input logic [15:0] c, input logic [47:0] l);
        @(negedge core_clk_i);
        cmd_valid_i = 1'b1;
        cmd_feature_i = f;
        cmd_count_i = c;
        cmd_lba_i = l;
        @(negedge core_clk_i);
        cmd_valid_i = 1'b0;
        `CK("rsp_valid", 1'b1, rsp_valid_o)
    endtask
    task ow(input logic [15:0] c, input logic [31:0] p);
        i_media_model.words.delete();
        cmd(16'h0014, c, {sanitize_pkg::OVERWRITE_KEY, p});
    endtask
    task abort(input logic [7:0] r);
        `CK("abort", 2'b11, {rsp_status_o[0], rsp_error_o[2]})
        `CK("reason", r, rsp_lba_o[7:0])
    endtask
    task wait_done;
        int n;
        n = 0;
        while (state_o === sanitize_pkg::SD2_RUNNING && n < 600) begin
            @(negedge core_clk_i);
            n++;
        end
    endtask
    task words(input logic [31:0] p, input logic inv, input logic alt,
        input int np, input int nw);
        logic [31:0] e;
        `CK("words", np * nw, i_media_model.words.size())
        for (int i = 0; i < i_media_model.words.size(); i++) begin
            e = (inv ^ (alt && ((i / nw) % 2 == 1))) ? ~p : p;
            `CK("word", e, i_media_model.words[i])
        end
    endtask
    task close_out;
        if (fail_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #200000;
        fail_count++;
        close_out();
    end
    // ****************
    // main sequence
    // ****************
    initial begin
        repeat (5) @(negedge core_clk_i);
        reset_i = 1'b0;
        @(negedge core_clk_i);
        `CK("state", sanitize_pkg::SD0_IDLE, state_o)
        for (int i = 0; i < 5; i++) begin
            cmd(rows[i].f, 16'h0000, rows[i].l);
            `CK("err", rows[i].e, rsp_status_o[0])
            `CK("abort", rows[i].e, rsp_error_o[2])
            `CK("lba", rows[i].r, rsp_lba_o[7:0])
        end
        cmd(16'h0011, 16'h0000, {16'h0, sanitize_pkg::CRYPTO_KEY});
        wait_done();
        `CK("state", sanitize_pkg::SD4_SUCCEEDED, state_o)
        `CK("nv_ok", 1'b1, nv_ok_o)
        ow(16'h00c2, 32'h1234_5678);
        cmd(16'h0000, 16'h0000, 48'h0);
        `CK("running", 1'b1, rsp_count_o[14])
        `CK("progress", 1'b1, rsp_lba_o[15:0] != 16'hffff)
        `CK("read_ok", 1'b0, media_read_ok_o)
        wait_done();
        words(32'h1234_5678, 1'b1, 1'b1, 2, 2);
        `CK("read_ok", 1'b1, media_read_ok_o)
        def_end_supported_i = 1'b0;
        ow(16'h00c2, 32'h1234_5678);
        wait_done();
        words(32'h1234_5678, 1'b0, 1'b1, 2, 2);
        def_end_supported_i = 1'b1;
        scope_words_i = 32'h1;
        ow(16'h0000, 32'h0f0f_a5a5);
        wait_done();
        words(32'h0f0f_a5a5, 1'b0, 1'b0, 16, 1);
        media_fault_i = 1'b1;
        ow(16'h0011, 32'h5555_0000);
        wait_done();
        media_fault_i = 1'b0;
        `CK("state", sanitize_pkg::SD3_FAILED, state_o)
        cmd(16'h0000, 16'h0000, 48'h0);
        abort(8'h01);
        cmd(16'h0000, 16'h0000, 48'h0);
        `CK("left", 1'b1, state_o !== sanitize_pkg::SD3_FAILED)
        media_fault_i = 1'b1;
        ow(16'h0001, 32'h5555_0000);
        wait_done();
        media_fault_i = 1'b0;
        ow(16'h0011, 32'h5555_0000);
        abort(8'h00);
        encryption_model_i = 1'b0;
        cmd(16'h0011, 16'h0000, {16'h0, sanitize_pkg::CRYPTO_KEY});
        abort(8'h02);
        encryption_model_i = 1'b1;
        cmd(16'h0011, 16'h0000, {16'h0, sanitize_pkg::CRYPTO_KEY});
        wait_done();
        `CK("state", sanitize_pkg::SD4_SUCCEEDED, state_o)
        antifreeze_i = 1'b1;
        cmd(16'h0020, 16'h0000, {16'h0, sanitize_pkg::FREEZE_KEY});
        abort(8'h04);
        antifreeze_i = 1'b0;
        cmd(16'h0020, 16'h0000, {16'h0, sanitize_pkg::FREEZE_KEY});
        `CK("state", sanitize_pkg::SD1_FROZEN, state_o)
        cmd(16'h0000, 16'h0000, 48'h0);
        `CK("frozen", 1'b1, rsp_count_o[13])
        ow(16'h0001, 32'h1);
        abort(8'h03);
        cmd(16'h0011, 16'h0000, {16'h0, sanitize_pkg::CRYPTO_KEY});
        abort(8'h03);
        reset_i = 1'b1;
        nv_ok_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
        reset_i = 1'b0;
        repeat (2) @(negedge core_clk_i);
        `CK("state", sanitize_pkg::SD4_SUCCEEDED, state_o)
        `CK("nv_ok", 1'b1, nv_ok_o)
        close_out();
    end
endmodule // sanitize_command_handler_tb
